// ### src/aslm_pkg.sv
package aslm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_RUN_CMD  = 4'h0;
  localparam logic [3:0] IDX_FSEL     = 4'h1;
  localparam logic [3:0] IDX_ALARM    = 4'h4;
  localparam logic [3:0] IDX_FWD_LIM  = 4'hc;
  localparam logic [3:0] IDX_REV_LIM  = 4'he;
  // Field positions
  localparam int FSEL_FWD_EN_BIT = 1;
  localparam int FSEL_REV_EN_BIT = 2;
  localparam int ALM_FWD_BIT     = 3;
  localparam int ALM_REV_BIT     = 4;
  localparam int RUN_CLR_ALM_BIT = 15;
  // Reset values
  localparam logic [15:0] RUN_CMD_RST = 16'h0000;
  localparam logic [15:0] FSEL_RST    = 16'h0000;
  localparam logic [31:0] FWD_LIM_RST = 32'h7fff_ffff;
  localparam logic [31:0] REV_LIM_RST = 32'h8000_0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  // Motion command classes
  localparam logic [3:0] CMD_NONE                        = 4'h0;
  localparam logic [3:0] CMD_ABSOLUTE_POSITIONING_MOVE   = 4'h1;
  localparam logic [3:0] CMD_EXTERNAL_TRIGGER_POSITIONING = 4'h2;
  localparam logic [3:0] CMD_JOG_FEED_MOVE               = 4'h3;
  localparam logic [3:0] CMD_STEP_MOVE                   = 4'h4;
  localparam logic [3:0] CMD_PATH_DISTRIBUTION_MOVE      = 4'h5;
  localparam logic [3:0] CMD_FINAL_PATH_SEGMENT_MOVE     = 4'h6;
  localparam logic [3:0] CMD_LATCH_MOVE                  = 4'h7;
  localparam logic [3:0] CMD_SPEED_CONTROL_MOVE          = 4'h8;
  localparam logic [3:0] CMD_TORQUE_CONTROL_MOVE         = 4'h9;
  localparam logic [3:0] CMD_PHASE_CONTROL_MOVE          = 4'ha;
  localparam logic [3:0] CMD_HOME_RETURN_MOVE            = 4'hb;
  // How a command class is brought to rest at a limit
  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_EARLY,
    STOP_HALT,
    STOP_LATE
  } aslm_stop_t;
endpackage

// ### src/aslm_monitor.sv
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module aslm_monitor #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Wishbone slave
  input  wire logic                 wb_cyc,
  input  wire logic                 wb_stb,
  input  wire logic                 wb_we,
  input  wire logic [ADDR_W-1:0]    wb_adr,
  input  wire logic [3:0]           wb_sel,
  input  wire logic [31:0]          wb_wdata,
  output logic      [31:0]          wb_rdata,
  output logic                      wb_ack,
  // Motion generator side
  input  wire logic                 cmd_valid,
  input  wire logic [3:0]           cmd_class,
  input  wire logic signed [31:0]   cmd_pos,
  input  wire logic [31:0]          stop_dist,
  input  wire logic                 home_done,
  // Limit status and stop requests
  output logic                      limits_armed,
  output logic                      fwd_alarm,
  output logic                      rev_alarm,
  output logic                      decel_ahead,
  output logic signed [31:0]        stop_target,
  output logic                      halt_distribution,
  output logic                      servo_estop,
  output logic                      decel_at_limit
);
  import aslm_pkg::*;

  // The decode reads address bits 5:2, so narrower buses cannot work
  if (ADDR_W < 6) begin : g_addr_w_check
    $error("ADDR_W must cover the register map");
  end

  logic [15:0]        run_cmd_q;
  logic [15:0]        fsel_q;
  logic signed [31:0] fwd_lim_q;
  logic signed [31:0] rev_lim_q;
  logic               homed_q;
  logic               fwd_alm_q;
  logic               rev_alm_q;
  logic               ack_q;
  logic [31:0]        rdata_q;
  logic               decel_ahead_q;
  logic signed [31:0] stop_target_q;
  logic               halt_q;
  logic               estop_q;
  logic               late_q;
  logic               armed_q;

  logic               req;
  logic               wr_go;
  logic [3:0]         idx;
  logic               hit_run;
  logic               hit_fsel;
  logic               hit_fwd;
  logic               hit_rev;
  logic               fixed_wr;
  logic               clr_alm;
  logic               chk_on;
  logic               fwd_on;
  logic               rev_on;
  logic               fwd_over;
  logic               rev_over;
  logic signed [32:0] fwd_reach;
  logic signed [32:0] rev_reach;
  logic               fwd_near;
  logic               rev_near;
  aslm_stop_t         kind;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode; upper address bits beyond the map must be zero
  assign req      = wb_cyc && wb_stb && !ack_q;
  assign wr_go    = req && wb_we;
  assign idx      = wb_adr[5:2];
  assign hit_run  = (wb_adr == ADDR_W'({IDX_RUN_CMD, 2'b00}));
  assign hit_fsel = (wb_adr == ADDR_W'({IDX_FSEL, 2'b00}));
  assign hit_fwd  = (wb_adr == ADDR_W'({IDX_FWD_LIM, 2'b00}));
  assign hit_rev  = (wb_adr == ADDR_W'({IDX_REV_LIM, 2'b00}));
  assign fixed_wr = wr_go && (hit_fsel || hit_fwd || hit_rev);
  assign clr_alm  = wr_go && hit_run && wb_sel[1]
                    && wb_wdata[RUN_CLR_ALM_BIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Unmapped addresses read zero and ignore writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= ZERO_WORD;
    end else if (req && !wb_we) begin
      rdata_q <= ZERO_WORD;
      if (hit_run) begin
        rdata_q <= {16'h0000, run_cmd_q};
      end else if (hit_fsel) begin
        rdata_q <= {16'h0000, fsel_q};
      end else if (idx == IDX_ALARM && wb_adr[1:0] == 2'b00
                   && wb_adr == ADDR_W'({IDX_ALARM, 2'b00})) begin
        rdata_q[ALM_FWD_BIT] <= fwd_alm_q;
        rdata_q[ALM_REV_BIT] <= rev_alm_q;
      end else if (hit_fwd) begin
        rdata_q <= fwd_lim_q;
      end else if (hit_rev) begin
        rdata_q <= rev_lim_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_cmd_q <= RUN_CMD_RST;
    end else if (wr_go && hit_run) begin
      run_cmd_q <= 16'(merge({16'h0000, run_cmd_q}, wb_wdata, wb_sel));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fsel_q    <= FSEL_RST;
      fwd_lim_q <= FWD_LIM_RST;
      rev_lim_q <= REV_LIM_RST;
    end else if (wr_go) begin
      if (hit_fsel) begin
        fsel_q <= 16'(merge({16'h0000, fsel_q}, wb_wdata, wb_sel));
      end
      if (hit_fwd) begin
        fwd_lim_q <= merge(fwd_lim_q, wb_wdata, wb_sel);
      end
      if (hit_rev) begin
        rev_lim_q <= merge(rev_lim_q, wb_wdata, wb_sel);
      end
    end
  end

  // Homed state; a completion in the same cycle as a write still counts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      homed_q <= 1'b0;
    end else if (home_done) begin
      homed_q <= 1'b1;
    end else if (fixed_wr) begin
      homed_q <= 1'b0;
    end
  end

  // Checking gates
  assign chk_on = homed_q && cmd_valid
                  && cmd_class != CMD_HOME_RETURN_MOVE;
  assign fwd_on = chk_on && fsel_q[FSEL_FWD_EN_BIT];
  assign rev_on = chk_on && fsel_q[FSEL_REV_EN_BIT];
  assign fwd_over = cmd_pos > fwd_lim_q;
  assign rev_over = cmd_pos < rev_lim_q;
  // Widened by one bit so the braking reach cannot wrap while stop_dist is at most 32'h8000_0000
  assign fwd_reach = {cmd_pos[31], cmd_pos} + {1'b0, stop_dist};
  assign rev_reach = {cmd_pos[31], cmd_pos} - {1'b0, stop_dist};
  // A bare concatenation is unsigned and would make the compare unsigned
  assign fwd_near  = fwd_reach >= $signed({fwd_lim_q[31], fwd_lim_q});
  assign rev_near  = rev_reach <= $signed({rev_lim_q[31], rev_lim_q});

  always_comb begin
    case (cmd_class)
      CMD_ABSOLUTE_POSITIONING_MOVE,
      CMD_EXTERNAL_TRIGGER_POSITIONING,
      CMD_JOG_FEED_MOVE,
      CMD_STEP_MOVE: kind = STOP_EARLY;
      CMD_PATH_DISTRIBUTION_MOVE,
      CMD_FINAL_PATH_SEGMENT_MOVE,
      CMD_LATCH_MOVE: kind = STOP_HALT;
      CMD_SPEED_CONTROL_MOVE,
      CMD_TORQUE_CONTROL_MOVE,
      CMD_PHASE_CONTROL_MOVE: kind = STOP_LATE;
      default: kind = STOP_NONE;
    endcase
  end

  // Alarms are sticky; a new violation wins over a clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fwd_alm_q <= 1'b0;
    end else if (fwd_on && fwd_over) begin
      fwd_alm_q <= 1'b1;
    end else if (clr_alm) begin
      fwd_alm_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rev_alm_q <= 1'b0;
    end else if (rev_on && rev_over) begin
      rev_alm_q <= 1'b1;
    end else if (clr_alm) begin
      rev_alm_q <= 1'b0;
    end
  end

  // Early braking follows the braking reach cycle by cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      decel_ahead_q <= 1'b0;
      stop_target_q <= FWD_LIM_RST;
    end else begin
      decel_ahead_q <= kind == STOP_EARLY
                       && ((fwd_on && fwd_near) || (rev_on && rev_near));
      if (kind == STOP_EARLY && fwd_on && fwd_near) begin
        stop_target_q <= fwd_lim_q;
      end else if (kind == STOP_EARLY && rev_on && rev_near) begin
        stop_target_q <= rev_lim_q;
      end
    end
  end

  // Hard and late stops latch until software clears the alarm
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      halt_q  <= 1'b0;
      estop_q <= 1'b0;
    end else if (kind == STOP_HALT
                 && ((fwd_on && fwd_over) || (rev_on && rev_over))) begin
      halt_q  <= 1'b1;
      estop_q <= 1'b1;
    end else if (clr_alm) begin
      halt_q  <= 1'b0;
      estop_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      late_q <= 1'b0;
    end else if (kind == STOP_LATE
                 && ((fwd_on && fwd_over) || (rev_on && rev_over))) begin
      late_q <= 1'b1;
    end else if (clr_alm) begin
      late_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= homed_q
                 && (fsel_q[FSEL_FWD_EN_BIT] || fsel_q[FSEL_REV_EN_BIT]);
    end
  end

  assign wb_ack            = ack_q;
  assign wb_rdata          = rdata_q;
  assign limits_armed      = armed_q;
  assign fwd_alarm         = fwd_alm_q;
  assign rev_alarm         = rev_alm_q;
  assign decel_ahead       = decel_ahead_q;
  assign stop_target       = stop_target_q;
  assign halt_distribution = halt_q;
  assign servo_estop       = estop_q;
  assign decel_at_limit    = late_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_fwd_enable_gate: assert property ($rose(fwd_alm_q) |->
    $past(fsel_q[FSEL_FWD_EN_BIT])) else $error("fwd alarm while off");
  a_limit_store: assert property (
    wr_go && hit_fwd && wb_sel == 4'hf |=> fwd_lim_q == $past(wb_wdata))
    else $error("fwd limit not stored");
  a_homed_gate: assert property (
    ($rose(fwd_alm_q) || $rose(rev_alm_q)) |-> $past(homed_q))
    else $error("alarm before homing");
  a_param_unhome: assert property (
    fixed_wr && !home_done |=> !homed_q) else $error("homed kept");
  a_alarm_raise: assert property (
    rev_on && rev_over |=> rev_alm_q) else $error("rev alarm missed");
  a_early_target: assert property (
    kind == STOP_EARLY && fwd_on && fwd_near |=>
      decel_ahead_q && stop_target_q == $past(fwd_lim_q))
    else $error("early stop wrong");
  a_rev_target: assert property (
    kind == STOP_EARLY && rev_on && rev_near && !(fwd_on && fwd_near) |=>
      decel_ahead_q && stop_target_q == $past(rev_lim_q))
    else $error("reverse early stop wrong");
  a_halt_estop: assert property (
    kind == STOP_HALT && fwd_on && fwd_over |=>
      halt_q && estop_q && !decel_ahead_q) else $error("halt missed");
  a_late_decel: assert property (
    kind == STOP_LATE && rev_on && rev_over |=> late_q &&
      (!halt_q || $past(halt_q) && !$past(clr_alm)))
    else $error("late stop missed");
  a_home_suppress: assert property (
    $rose(fwd_alm_q) |-> $past(cmd_class) != CMD_HOME_RETURN_MOVE)
    else $error("alarm during home return");
  a_alarm_readback: assert property (
    req && !wb_we && wb_adr == ADDR_W'({IDX_ALARM, 2'b00}) |=>
      wb_ack && wb_rdata[ALM_FWD_BIT] == $past(fwd_alm_q)
      && wb_rdata[ALM_REV_BIT] == $past(rev_alm_q))
    else $error("alarm readback wrong");
  a_alarm_clear: assert property (
    clr_alm && !(fwd_on && fwd_over) |=> !fwd_alm_q)
    else $error("clear ignored");
  a_alarm_sticky: assert property (
    fwd_alm_q && !clr_alm |=> fwd_alm_q [*1]) else $error("alarm lost");
  a_bus_ack_once: assert property (
    req |=> wb_ack ##1 !wb_ack) else $error("ack not one cycle");

  c_fwd_alarm: cover property (fwd_on && fwd_over ##1 clr_alm);
  c_early_stop: cover property (kind == STOP_EARLY && rev_on && rev_near);
  c_halt_stop: cover property ($rose(halt_q));
  c_rehome: cover property (fixed_wr ##[1:20] home_done);
endmodule

// ### test/aslm_motion_model.sv
`timescale 1ns/1ps
module aslm_motion_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Requests from the bench
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_class,
  input  wire logic [31:0] req_pos,
  input  wire logic [31:0] req_dist,
  input  wire logic        req_home,
  // Motion command towards the monitor
  output logic             cmd_valid,
  output logic [3:0]       cmd_class,
  output logic [31:0]      cmd_pos,
  output logic [31:0]      stop_dist,
  output logic             home_done
);
  logic home_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_class <= 4'h0;
      cmd_pos   <= 32'h0000_0000;
      stop_dist <= 32'h0000_0000;
    end else begin
      cmd_valid <= req_valid;
      cmd_class <= req_class;
      cmd_pos   <= req_pos;
      stop_dist <= req_dist;
    end
  end

  // Homing completion is one pulse however long the request stays up
  always_ff @(posedge sys_clk) begin
    home_q    <= rst ? 1'b0 : req_home;
    home_done <= ~rst & req_home & ~home_q;
  end
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  import aslm_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_wdata = 32'h0000_0000, wb_rdata, stop_dist;
  logic req_valid = 1'b0, req_home = 1'b0, cmd_valid, home_done;
  logic [3:0] req_class = 4'h0, cmd_class;
  logic [31:0] req_pos = 32'h0000_0000, req_dist = 32'h0000_0000;
  logic signed [31:0] cmd_pos, stop_target;
  logic limits_armed, fwd_alarm, rev_alarm, decel_ahead;
  logic halt_distribution, servo_estop, decel_at_limit;
  int failures = 0, check_count = 0, cycles = 0;
  localparam logic [31:0] FWD = 32'h0000_03e8, REV = 32'hffff_fc18;

  always #12.5 sys_clk = ~sys_clk;

  aslm_monitor i_aslm_monitor (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_wdata(wb_wdata), .wb_rdata(wb_rdata),
    .wb_ack(wb_ack), .cmd_valid(cmd_valid), .cmd_class(cmd_class),
    .cmd_pos(cmd_pos), .stop_dist(stop_dist), .home_done(home_done),
    .limits_armed(limits_armed), .fwd_alarm(fwd_alarm),
    .rev_alarm(rev_alarm), .decel_ahead(decel_ahead),
    .stop_target(stop_target), .halt_distribution(halt_distribution),
    .servo_estop(servo_estop), .decel_at_limit(decel_at_limit));

  aslm_motion_model i_aslm_motion_model (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req_class(req_class), .req_pos(req_pos),
    .req_dist(req_dist), .req_home(req_home), .cmd_valid(cmd_valid),
    .cmd_class(cmd_class), .cmd_pos(cmd_pos), .stop_dist(stop_dist),
    .home_done(home_done));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish;
    end
  end

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; only the bench timeout ends a wait for ack
  task automatic wb(input logic we, input logic [3:0] idx,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {idx, 2'b00};
    wb_wdata <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack !== 1'b1);
    q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 32'h0000_0000, q);
    chk32(q, exp);
  endtask

  // Model adds one cycle, monitor one more
  task automatic move(input logic [3:0] c, input logic [31:0] p,
                      input logic [31:0] d);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_class <= c;
    req_pos   <= p;
    req_dist  <= d;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic home;
    @(posedge sys_clk);
    req_home <= 1'b1;
    @(posedge sys_clk);
    req_home <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic back_and_clear;
    move(CMD_JOG_FEED_MOVE, 32'h0000_0000, 32'h0000_0000);
    chk1(fwd_alarm | rev_alarm, 1'b1);
    wr(IDX_RUN_CMD, 32'h0000_8000);
    chk1(fwd_alarm | rev_alarm | halt_distribution, 1'b0);
    chk1(servo_estop | decel_at_limit, 1'b0);
  endtask

  task automatic t_regs;
    rd_chk(IDX_RUN_CMD, 32'h0000_0000);
    rd_chk(IDX_FSEL, 32'h0000_0000);
    rd_chk(IDX_FWD_LIM, 32'h7fff_ffff);
    rd_chk(IDX_REV_LIM, 32'h8000_0000);
    rd_chk(4'h2, 32'h0000_0000);
    wr(IDX_ALARM, 32'hffff_ffff);
    rd_chk(IDX_ALARM, 32'h0000_0000);
    $display("registers test done");
  endtask

  task automatic t_arming;
    wr(IDX_FSEL, 32'h0000_0006);
    wr(IDX_FWD_LIM, FWD);
    wr(IDX_REV_LIM, REV);
    move(CMD_ABSOLUTE_POSITIONING_MOVE, 32'h0000_07d0, 32'h0000_0000);
    chk1(fwd_alarm | limits_armed, 1'b0);
    move(CMD_HOME_RETURN_MOVE, 32'h0000_07d0, 32'h0000_0000);
    home;
    chk1(limits_armed, 1'b1);
    chk1(fwd_alarm, 1'b0);
    $display("arming test done");
  endtask

  task automatic t_classes;
    for (int c = 1; c <= 10; c++) begin
      move(4'(c), FWD + 32'h0000_0001, 32'h0000_0000);
      chk1(fwd_alarm, 1'b1);
      rd_chk(IDX_ALARM, 32'h0000_0008);
      chk1(decel_ahead, c <= 4);
      chk1(halt_distribution & servo_estop, c >= 5 && c <= 7);
      chk1(decel_at_limit, c >= 8);
      if (c <= 4)
        chk32(stop_target, FWD);
      back_and_clear;
    end
    move(CMD_ABSOLUTE_POSITIONING_MOVE, 32'h0000_0384, 32'h0000_0064);
    chk1(decel_ahead & ~fwd_alarm, 1'b1);
    move(CMD_ABSOLUTE_POSITIONING_MOVE, 32'h0000_0383, 32'h0000_0064);
    chk1(decel_ahead, 1'b0);
    move(CMD_STEP_MOVE, 32'hffff_fc7c, 32'h0000_0064);
    chk1(decel_ahead & ~rev_alarm, 1'b1);
    chk32(stop_target, REV);
    $display("command class test done");
  endtask

  task automatic t_enables;
    wr(IDX_FSEL, 32'h0000_0002);
    chk1(limits_armed, 1'b0);
    home;
    move(CMD_PATH_DISTRIBUTION_MOVE, REV - 32'h0000_0001, 32'h0000_0000);
    chk1(rev_alarm, 1'b0);
    wr(IDX_FSEL, 32'h0000_0004);
    home;
    move(CMD_PATH_DISTRIBUTION_MOVE, REV - 32'h0000_0001, 32'h0000_0000);
    chk1(rev_alarm & ~fwd_alarm, 1'b1);
    rd_chk(IDX_ALARM, 32'h0000_0010);
    back_and_clear;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk1(limits_armed, 1'b0);
    $display("enable and rehome test done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_arming;
    t_classes;
    t_enables;
    tally_and_finish;
  end
endmodule
